// File: rtl/ispm_pkg.sv
package ispm_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] routing_config_offset = 8'h03;
	localparam int routing_width = 7;
	localparam logic [6:0] routing_reset = 7'h00;
	localparam logic [7:0] mode_offset = 8'h10;
	localparam logic [7:0] status_offset = 8'h11;
	localparam logic [3:0] mode_reset = 4'h0;
	// ==========================================================
	// field positions
	localparam int cfg_lsb = 0;
	localparam int inv_bit = 3;
	localparam int ref_lsb = 4;
	// ==========================================================
	// codes
	localparam logic [2:0] cfg_diff = 3'h0;
	localparam logic [2:0] cfg_single_cross = 3'h2;
	localparam logic [2:0] cfg_double_cross = 3'h3;
	localparam logic [2:0] cfg_se = 3'h4;
	localparam logic [2:0] cfg_se_cross = 3'h7;
	localparam logic [1:0] ref_own = 2'h0;
	localparam logic [1:0] ref_out = 2'h2;
	localparam logic [1:0] ref_ext = 2'h3;
	localparam logic [6:0] bypass_code = 7'h40;
	localparam logic [3:0] bypass_mode = 4'h6;
	// pin selector codes, pin x1..x6 = 0..5
	localparam logic [2:0] pin_x1 = 3'h0;
	localparam logic [2:0] pin_x2 = 3'h1;
	localparam logic [2:0] pin_x3 = 3'h2;
	localparam logic [2:0] pin_x4 = 3'h3;
	localparam logic [2:0] pin_x5 = 3'h4;
	localparam logic [2:0] pin_x6 = 3'h5;
	// reference source for the channels
	typedef enum logic [2:0] {
		ispm_ref_internal = 3'b001,
		ispm_ref_sincos = 3'b010,
		ispm_ref_external = 3'b100
	} ispm_ref_type;
endpackage : ispm_pkg

// File: rtl/ispm_sel_if.sv
`timescale 1ns/1ps
interface ispm_sel_if;
	logic [2:0] cos_pos;
	logic [2:0] cos_neg;
	logic [2:0] sin_neg;
	logic index_swap;
	logic bypass;
	ispm_pkg::ispm_ref_type ref_src;
	logic x2_ref_out;
	logic x2_ref_in;
	logic cfg_valid;
	modport dec(output cos_pos, cos_neg, sin_neg, index_swap, bypass, ref_src,
		x2_ref_out, x2_ref_in, cfg_valid);
	modport use_sel(input cos_pos, cos_neg, sin_neg, index_swap, bypass, ref_src,
		x2_ref_out, x2_ref_in, cfg_valid);
endinterface : ispm_sel_if

// File: rtl/ispm_decode.sv
`timescale 1ns/1ps
module ispm_decode (
	input wire logic [6:0] cfg,
	input wire logic [3:0] mode,
	ispm_sel_if.dec sel
);
	logic [2:0] code;
	logic [1:0] refsel;
	assign code = cfg[ispm_pkg::cfg_lsb +: 3];
	assign refsel = cfg[ispm_pkg::ref_lsb +: 2];
	// ==========================================================
	// input configuration
	always_comb begin
		sel.cos_pos = ispm_pkg::pin_x3;
		sel.cos_neg = ispm_pkg::pin_x5;
		sel.sin_neg = ispm_pkg::pin_x6;
		sel.cfg_valid = 1'b1;
		unique case (code)
			ispm_pkg::cfg_diff: begin // [RL3]
				sel.cos_neg = ispm_pkg::pin_x5;
			end
			ispm_pkg::cfg_single_cross: begin // [RL3]
				sel.cos_neg = ispm_pkg::pin_x6;
				sel.sin_neg = ispm_pkg::pin_x5;
			end
			ispm_pkg::cfg_double_cross: begin // [RL3]
				sel.cos_pos = ispm_pkg::pin_x5;
				sel.cos_neg = ispm_pkg::pin_x6;
				sel.sin_neg = ispm_pkg::pin_x3;
			end
			ispm_pkg::cfg_se: begin // [RL4]
				sel.cos_neg = ispm_pkg::pin_x2;
				sel.sin_neg = ispm_pkg::pin_x2;
			end
			ispm_pkg::cfg_se_cross: begin // [RL4]
				sel.cos_pos = ispm_pkg::pin_x5;
				sel.cos_neg = ispm_pkg::pin_x2;
				sel.sin_neg = ispm_pkg::pin_x2;
			end
			default: begin
				// undefined codes keep the differential routing
				sel.cfg_valid = 1'b0;
			end
		endcase
	end
	// ==========================================================
	// index polarity, reference and bypass
	assign sel.index_swap = cfg[ispm_pkg::inv_bit]; // [RL5]
	assign sel.bypass = (cfg == ispm_pkg::bypass_code) && (mode == ispm_pkg::bypass_mode); // [RL9]
	always_comb begin
		sel.ref_src = ispm_pkg::ispm_ref_internal; // [RL6]
		sel.x2_ref_out = 1'b0;
		sel.x2_ref_in = 1'b0;
		if (refsel == ispm_pkg::ref_out) begin
			sel.ref_src = ispm_pkg::ispm_ref_sincos; // [RL7]
			sel.x2_ref_out = 1'b1;
		end else if (refsel == ispm_pkg::ref_ext) begin
			sel.ref_src = ispm_pkg::ispm_ref_external; // [RL8]
			sel.x2_ref_in = 1'b1;
		end
	end
endmodule : ispm_decode

// File: rtl/ispm_top.sv
`timescale 1ns/1ps
// Function
// RL1: index inputs always from x1 and x2
// RL2: x4 always feeds sine positive input
// RL3: codes 0,2,3 route cosine and sine negative
// RL4: single-ended codes 4,7 use x2 negatives
// RL5: bit 3 swaps index outputs
// RL6: reference code 0 uses own references
// RL7: code 2 shares sincos reference, drives x2
// RL8: code 3 takes external reference on x2
// RL9: 0x40 with mode 6 bypasses amplifiers
// RL10: software writes only defined routing values
// RL11: b pair cosine, a pair sine normally
// RL12: routing register writable, selects follow directly
module ispm_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [5:0] pin_x,
	input wire logic [5:0] amp_out,
	output logic index_pos_input,
	output logic index_neg_input,
	output logic sine_pos_input,
	output logic sine_neg_input,
	output logic cosine_pos_input,
	output logic cosine_neg_input,
	output logic index_pos_output,
	output logic index_neg_output,
	output logic pin_pb,
	output logic pin_nb,
	output logic pin_pa,
	output logic pin_na,
	output logic pin_pz,
	output logic pin_nz,
	output logic [2:0] channel_ref_sel,
	output logic x2_ref_out_oe_n,
	output logic x2_ref_in_en
);
	// amp_out: index p/n, sine p/n, cosine p/n amplifier outputs (0..5)
	logic [6:0] input_routing_config;
	logic [3:0] op_mode;
	ispm_sel_if sel ();

	// ==========================================================
	// register file
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			input_routing_config <= ispm_pkg::routing_reset;
		end else if (wr && addr == ispm_pkg::routing_config_offset) begin
			input_routing_config <= wdata[6:0]; // [RL12]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			op_mode <= ispm_pkg::mode_reset;
		end else if (wr && addr == ispm_pkg::mode_offset) begin
			op_mode <= wdata[3:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				ispm_pkg::routing_config_offset: rdata <= {1'b0, input_routing_config};
				ispm_pkg::mode_offset: rdata <= {4'h0, op_mode};
				ispm_pkg::status_offset: rdata <= {3'h0, sel.x2_ref_in, sel.x2_ref_out,
					sel.index_swap, sel.bypass, sel.cfg_valid};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// selects follow the register with no extra stage
	ispm_decode u_dec (
		.cfg(input_routing_config),
		.mode(op_mode),
		.sel(sel)
	);

	// ==========================================================
	// analog path model as digital selects
	function automatic logic pick(input logic [5:0] pins, input logic [2:0] idx);
		pick = (idx < 3'h6) ? pins[idx] : 1'b0;
	endfunction : pick

	assign index_pos_input = pin_x[ispm_pkg::pin_x1]; // [RL1]
	assign index_neg_input = pin_x[ispm_pkg::pin_x2]; // [RL1]
	assign sine_pos_input = pin_x[ispm_pkg::pin_x4]; // [RL2]
	assign sine_neg_input = pick(pin_x, sel.sin_neg); // [RL3] [RL4]
	assign cosine_pos_input = pick(pin_x, sel.cos_pos); // [RL3] [RL4]
	assign cosine_neg_input = pick(pin_x, sel.cos_neg); // [RL3] [RL4]
	assign index_pos_output = sel.index_swap ? amp_out[1] : amp_out[0]; // [RL5]
	assign index_neg_output = sel.index_swap ? amp_out[0] : amp_out[1]; // [RL5]

	// bypass hands the raw pins straight to the drivers
	always_comb begin
		if (sel.bypass) begin
			pin_pb = pin_x[ispm_pkg::pin_x3]; // [RL9]
			pin_nb = pin_x[ispm_pkg::pin_x5];
			pin_pa = pin_x[ispm_pkg::pin_x4];
			pin_na = pin_x[ispm_pkg::pin_x6];
			pin_pz = pin_x[ispm_pkg::pin_x1];
			pin_nz = pin_x[ispm_pkg::pin_x2];
		end else begin
			pin_pb = amp_out[4]; // [RL11]
			pin_nb = amp_out[5];
			pin_pa = amp_out[2];
			pin_na = amp_out[3];
			pin_pz = index_pos_output;
			pin_nz = index_neg_output;
		end
	end

	assign channel_ref_sel = sel.ref_src; // [RL6] [RL7] [RL8]
	// low enable while x2 carries the sincos reference out
	assign x2_ref_out_oe_n = ~sel.x2_ref_out; // [RL7]
	assign x2_ref_in_en = sel.x2_ref_in; // [RL8]

	// ==========================================================
	// checks
	sequence wr_cfg_s;
		wr && addr == ispm_pkg::routing_config_offset;
	endsequence
	sequence wr_mode_s;
		wr && addr == ispm_pkg::mode_offset;
	endsequence
	sequence rd_cfg_s;
		rd && addr == ispm_pkg::routing_config_offset;
	endsequence
	sequence rd_status_s;
		rd && addr == ispm_pkg::status_offset;
	endsequence
	sequence rd_idle_s;
		!rd;
	endsequence

	reg_update_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL12]
		wr_cfg_s |=> input_routing_config == $past(wdata[6:0]))
		else $error("routing register not updated");
	mode_update_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
		wr_mode_s |=> op_mode == $past(wdata[3:0]))
		else $error("mode register not updated");
	cfg_readback_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL12]
		rd_cfg_s |=> rdata == {1'b0, $past(input_routing_config)})
		else $error("routing register read back wrong");
	status_read_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL7] [RL8]
		rd_status_s |=> rdata[7:3] == {3'h0, $past(x2_ref_in_en), !$past(x2_ref_out_oe_n)})
		else $error("status reference bits wrong");
	rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL12]
		rd_idle_s |=> rdata == 8'h00)
		else $error("read data not cleared");
	index_fixed_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL1]
		index_pos_input == pin_x[0] && index_neg_input == pin_x[1])
		else $error("index input not from x1 x2");
	sine_pos_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL2]
		sine_pos_input == pin_x[3])
		else $error("sine positive not from x4");
	diff_route_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL3]
		input_routing_config[2:0] == 3'h0 |-> cosine_pos_input == pin_x[2]
		&& cosine_neg_input == pin_x[4] && sine_neg_input == pin_x[5])
		else $error("differential routing wrong");
	single_cross_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL3]
		input_routing_config[2:0] == 3'h2 |-> cosine_pos_input == pin_x[2]
		&& cosine_neg_input == pin_x[5] && sine_neg_input == pin_x[4])
		else $error("single crossing routing wrong");
	cross_route_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL3]
		input_routing_config[2:0] == 3'h3 |-> cosine_pos_input == pin_x[4]
		&& cosine_neg_input == pin_x[5] && sine_neg_input == pin_x[2])
		else $error("double crossing routing wrong");
	se_route_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
		input_routing_config[2] && input_routing_config[1:0] != 2'h1
		&& input_routing_config[1:0] != 2'h2 |-> cosine_neg_input == pin_x[1]
		&& sine_neg_input == pin_x[1])
		else $error("single ended negatives not x2");
	se_pos_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
		input_routing_config[2:0] == 3'h4 |-> cosine_pos_input == pin_x[2])
		else $error("single ended positive not x3");
	se_cross_pos_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
		input_routing_config[2:0] == 3'h7 |-> cosine_pos_input == pin_x[4])
		else $error("crossed single ended positive not x5");
	index_swap_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL5]
		input_routing_config[3] |-> index_pos_output == amp_out[1]
		&& index_neg_output == amp_out[0])
		else $error("index swap wrong");
	index_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL5]
		!input_routing_config[3] |-> index_pos_output == amp_out[0]
		&& index_neg_output == amp_out[1])
		else $error("index polarity not kept");
	ref_own_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL6]
		input_routing_config[5:4] == 2'h0 |-> x2_ref_out_oe_n && !x2_ref_in_en
		&& channel_ref_sel == 3'b001)
		else $error("x2 used as reference in code 0");
	ref_out_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL7]
		wr_cfg_s ##1 input_routing_config[5:4] == 2'h2 |-> !x2_ref_out_oe_n
		&& channel_ref_sel == 3'b010)
		else $error("reference output not enabled");
	ref_shared_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL7]
		input_routing_config[5:4] == 2'h2 |-> !x2_ref_out_oe_n && !x2_ref_in_en
		&& channel_ref_sel == 3'b010)
		else $error("shared reference not held");
	ref_ext_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL8]
		input_routing_config[5:4] == 2'h3 |-> x2_ref_in_en && x2_ref_out_oe_n
		&& channel_ref_sel == 3'b100)
		else $error("external reference not selected");
	// driving x2 while an outside source sits on it would fight that source
	x2_excl_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL7] [RL8]
		!(x2_ref_in_en && !x2_ref_out_oe_n))
		else $error("x2 driven and taken in at once");
	bypass_path_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
		input_routing_config == 7'h40 && op_mode == 4'h6 |-> pin_pb == pin_x[2]
		&& pin_nb == pin_x[4] && pin_pa == pin_x[3] && pin_na == pin_x[5]
		&& pin_pz == pin_x[0] && pin_nz == pin_x[1])
		else $error("bypass routing wrong");
	normal_out_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL11]
		!(input_routing_config == 7'h40 && op_mode == 4'h6) |-> pin_pb == amp_out[4]
		&& pin_nb == amp_out[5] && pin_pa == amp_out[2] && pin_na == amp_out[3])
		else $error("output pairs not from channels");
	index_out_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL11]
		!(input_routing_config == 7'h40 && op_mode == 4'h6) |-> pin_pz == index_pos_output
		&& pin_nz == index_neg_output)
		else $error("z pair not from index channel");
endmodule : ispm_top

// File: verification/ispm_amp_model.sv
`timescale 1ns/1ps
// ==========================================================
// amplifier stand-in: inverting stage, output lags its inputs
module ispm_amp_model #(
	parameter real settle_ns = 1.0
) (
	input wire logic index_pos_input,
	input wire logic index_neg_input,
	input wire logic sine_pos_input,
	input wire logic sine_neg_input,
	input wire logic cosine_pos_input,
	input wire logic cosine_neg_input,
	output logic [5:0] amp_out
);
	// inversion keeps amplifier paths apart from raw pin paths
	assign #(settle_ns) amp_out = ~{cosine_neg_input, cosine_pos_input, sine_neg_input,
		sine_pos_input, index_neg_input, index_pos_input};
endmodule : ispm_amp_model

// File: verification/input_signal_path_mux_test.sv
`timescale 1ns/1ps
module input_signal_path_mux_test;
	typedef struct {logic is_rd; logic [18:0] v;} ispm_note_type;
	logic ref_clk, rst, wr, rd, pz, nz, ip, inn, sp, sn, cp, cn, iop, ion, pb, nb, pa, na;
	logic oe_n, in_en;
	logic [7:0] addr, wdata, rdata;
	logic [5:0] pin_x, amp_out;
	logic [2:0] ref_sel;
	logic [6:0] cur_cfg;
	logic [3:0] cur_mode;
	ispm_note_type notes[$];
	int num_errors, check_count;
	int cycles = 0;
	logic [18:0] outs;
	integer seed;
	logic [2:0] codes[5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h7};
	logic [1:0] refs[3] = '{2'h0, 2'h2, 2'h3};
	ispm_top i_ispm_top (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .pin_x(pin_x), .amp_out(amp_out), .index_pos_input(ip),
		.index_neg_input(inn), .sine_pos_input(sp), .sine_neg_input(sn),
		.cosine_pos_input(cp), .cosine_neg_input(cn), .index_pos_output(iop),
		.index_neg_output(ion), .pin_pb(pb), .pin_nb(nb), .pin_pa(pa), .pin_na(na),
		.pin_pz(pz), .pin_nz(nz), .channel_ref_sel(ref_sel), .x2_ref_out_oe_n(oe_n),
		.x2_ref_in_en(in_en));
	ispm_amp_model i_ispm_amp_model (.index_pos_input(ip), .index_neg_input(inn),
		.sine_pos_input(sp), .sine_neg_input(sn), .cosine_pos_input(cp),
		.cosine_neg_input(cn), .amp_out(amp_out));
	assign outs = {ip, inn, sp, sn, cp, cn, iop, ion, pb, nb, pa, na, pz, nz,
		ref_sel, oe_n, in_en};
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// expectations
	function automatic logic [18:0] exp_route(logic [6:0] c, logic [3:0] m, logic [5:0] x);
		logic [2:0] r;
		logic [5:0] a;
		logic byp;
		logic [1:0] io;
		case (c[2:0])
			3'h2: r = {x[2], x[5], x[4]};
			3'h3: r = {x[4], x[5], x[2]};
			3'h4: r = {x[2], x[1], x[1]};
			3'h7: r = {x[4], x[1], x[1]};
			default: r = {x[2], x[4], x[5]};
		endcase
		a = ~{r[1], r[2], r[0], x[3], x[1], x[0]};
		io = c[3] ? {a[1], a[0]} : {a[0], a[1]};
		byp = (c == 7'h40) && (m == 4'h6);
		return {x[0], x[1], x[3], r[0], r[2], r[1], io,
			byp ? {x[2], x[4], x[3], x[5], x[0], x[1]} : {a[4], a[5], a[2], a[3], io},
			c[5:4] == 2'h2 ? 3'b010 : (c[5:4] == 2'h3 ? 3'b100 : 3'b001),
			c[5:4] != 2'h2, c[5:4] == 2'h3};
	endfunction : exp_route
	function automatic logic [7:0] exp_status(logic [6:0] c, logic [3:0] m);
		return {3'h0, c[5:4] == 2'h3, c[5:4] == 2'h2, c[3], (c == 7'h40) && (m == 4'h6), 1'b1};
	endfunction : exp_status
	// ==========================================================
	// bus driver
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
	endtask : op
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic [5:0] px;
		op(1'b1, 1'b0, a, d);
		if (a == 8'h03) cur_cfg = d[6:0];
		if (a == 8'h10) cur_mode = d[3:0];
		px = $random(seed);
		pin_x <= px;
		notes.push_back('{1'b0, exp_route(cur_cfg, cur_mode, px)});
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		op(1'b0, 1'b1, a, 8'h00);
		notes.push_back('{1'b1, {11'h000, e}});
	endtask : rd_reg
	// ==========================================================
	// monitor
	task automatic chk(input string what, input logic [18:0] seen, input logic [18:0] e);
		check_count++;
		if (seen !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, e, seen);
		end
	endtask : chk
	always @(negedge ref_clk) begin
		while (notes.size() > 0) begin
			if (notes[0].is_rd) chk("rdata", {11'h000, rdata}, notes[0].v);
			else chk("routing", outs, notes[0].v);
			void'(notes.pop_front());
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// hang guard, well above the 163 cycles the tests need
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			end_sim();
		end
	end
	// ==========================================================
	// tests
	initial begin
		seed = 32'hab90;
		rst = 1'b1;
		{wr, rd, addr, wdata, pin_x} = 24'h000000;
		cur_mode = ispm_pkg::mode_reset;
		cur_cfg = ispm_pkg::routing_reset;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		wr_reg(8'h20, 8'hff);
		rd_reg(8'h03, {1'b0, ispm_pkg::routing_reset});
		rd_reg(8'h10, 8'h00);
		rd_reg(8'h20, 8'h00);
		$display("test reset and unmapped done");
		for (int c = 0; c < 5; c++) for (int r = 0; r < 3; r++) for (int i = 0; i < 2; i++) begin
			wr_reg(8'h03, {1'b0, refs[r], i[0], codes[c]});
			rd_reg(8'h03, {1'b0, cur_cfg});
			rd_reg(8'h11, exp_status(cur_cfg, cur_mode));
		end
		$display("test code table done");
		wr_reg(8'h10, 8'h06);
		wr_reg(8'h03, 8'h40);
		rd_reg(8'h11, exp_status(cur_cfg, cur_mode));
		wr_reg(8'h10, 8'h05);
		wr_reg(8'h10, 8'h06);
		wr_reg(8'h03, 8'h00);
		rd_reg(8'h10, 8'h06);
		$display("test bypass done");
		// software keeps to defined routing values only
		repeat (40) wr_reg(8'h03, {1'b0, refs[$unsigned($random(seed)) % 3], 1'($random(seed)),
			codes[$unsigned($random(seed)) % 5]});
		rd_reg(8'h03, {1'b0, cur_cfg});
		$display("test random routing done");
		op(1'b0, 1'b0, 8'h00, 8'h00);
		// second reset in mid-run must clear both registers
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		cur_cfg = ispm_pkg::routing_reset;
		cur_mode = ispm_pkg::mode_reset;
		wr_reg(8'h20, 8'h5a);
		rd_reg(8'h03, {1'b0, ispm_pkg::routing_reset});
		rd_reg(8'h10, {4'h0, ispm_pkg::mode_reset});
		$display("test mid-run reset done");
		op(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (3) @(posedge ref_clk);
		end_sim();
	end
endmodule : input_signal_path_mux_test
